// [mux16_sar_adc_map.svh]
// constants for the sixteen-input successive-approximation converter control
`ifndef MUX16_SAR_ADC_MAP_SVH
`define MUX16_SAR_ADC_MAP_SVH
`define ADC_CHANNELS 16
`define ADC_SEL_BITS 4
`define ADC_RESULT_BITS 8
`define ADC_CLKS_PER_BIT 8
`define ADC_BITS_PER_CONV 8
`define ADC_CLK_CNT_BITS 3
`define ADC_BIT_IDX_BITS 3
`define ADC_CLK_PERIOD_PS 4000
`define ADC_SETTLE_TIME_NS 2500
`define ADC_SETTLE_CYCLES ((`ADC_SETTLE_TIME_NS * 1000) / `ADC_CLK_PERIOD_PS)
`define ADC_RESULT_RESET 8'h00
`define ADC_SAR_FIRST_TRIAL 8'h80
`define ADC_SELECT_RESET 16'h0000
`endif

// [mux16_sar_adc_pkg.sv]
// types shared by the converter control modules
package mux16_sar_adc_pkg;
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_ARMED = 2'b01,
    CONV_RUN = 2'b10
  } conv_state_t;
  typedef logic [7:0] result_t;
  typedef logic [15:0] channel_onehot_t;
endpackage : mux16_sar_adc_pkg

// [mux_select_if.sv]
// channel selection carried from the latch to the converter core
interface mux_select_if;
  logic [15:0] select_onehot;
  logic channel_enabled;
  logic latch_event;
  modport latch (output select_onehot, output channel_enabled,
    output latch_event);
  modport core (input select_onehot, input channel_enabled,
    input latch_event);
endinterface : mux_select_if

// [channel_latch.sv]
// address latch and sixteen-way channel decoder
`include "mux16_sar_adc_map.svh"
module channel_latch (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic address_latch_strobe,
  input wire logic channel_expansion,
  input wire logic [3:0] channel_address,
  mux_select_if.latch sel
);
  logic strobe_reg;
  logic strobe_next;
  mux16_sar_adc_pkg::channel_onehot_t onehot_reg;
  mux16_sar_adc_pkg::channel_onehot_t onehot_next;
  logic enabled_reg;
  logic enabled_next;
  logic event_reg;
  logic event_next;
  logic rise;

  always_comb begin
    rise = address_latch_strobe & ~strobe_reg;
    strobe_next = address_latch_strobe;
    onehot_next = onehot_reg;
    enabled_next = enabled_reg;
    event_next = rise;
    if (rise) begin
      enabled_next = channel_expansion;
      if (channel_expansion) begin
        // select bit 3 is most significant
        onehot_next = 16'h0001 << channel_address;
      end else begin
        onehot_next = `ADC_SELECT_RESET; // all channels off
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_reg <= 1'b0;
      onehot_reg <= `ADC_SELECT_RESET;
      enabled_reg <= 1'b0;
      event_reg <= 1'b0;
    end else begin
      strobe_reg <= strobe_next;
      onehot_reg <= onehot_next;
      enabled_reg <= enabled_next;
      event_reg <= event_next;
    end
  end

  assign sel.select_onehot = onehot_reg;
  assign sel.channel_enabled = enabled_reg;
  assign sel.latch_event = event_reg;
endmodule : channel_latch

// [mux16_sar_adc_control.sv]
// successive-approximation converter control with sixteen-way input select
// Operation
// - route at most one of sixteen inputs, or none when expansion is off at the strobe rise
// - latch address on strobe rising edge
// - four select bits choose input index
// - each conversion yields an 8-bit code
// - approximation register decides bits in turn
// - clear on trigger rise, run after fall
// - new trigger abandons running conversion
// - eight decisions of eight clocks each
// - done falls within eight clocks of trigger
`include "mux16_sar_adc_map.svh"
module mux16_sar_adc_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic address_latch_strobe,
  input wire logic channel_expansion,
  input wire logic [3:0] channel_address,
  input wire logic conversion_trigger,
  input wire logic comparator_above,
  output logic [15:0] analog_select,
  output logic [7:0] ladder_trial,
  output logic [7:0] conversion_result,
  output logic conversion_done,
  output logic channel_settled
);
  localparam int SETTLE_CYCLES = `ADC_SETTLE_CYCLES;

  mux_select_if sel_bus ();

  channel_latch u_latch (
    .clk(clk),
    .rst_n(rst_n),
    .address_latch_strobe(address_latch_strobe),
    .channel_expansion(channel_expansion),
    .channel_address(channel_address),
    .sel(sel_bus)
  );

  mux16_sar_adc_pkg::conv_state_t state_reg;
  mux16_sar_adc_pkg::conv_state_t state_next;
  logic trig_reg;
  logic trig_next;
  mux16_sar_adc_pkg::result_t approximation_register_reg;
  mux16_sar_adc_pkg::result_t approximation_register_next;
  mux16_sar_adc_pkg::result_t trial_bit_reg;
  mux16_sar_adc_pkg::result_t trial_bit_next;
  logic [2:0] clk_cnt_reg;
  logic [2:0] clk_cnt_next;
  logic [2:0] bit_idx_reg;
  logic [2:0] bit_idx_next;
  mux16_sar_adc_pkg::result_t result_reg;
  mux16_sar_adc_pkg::result_t result_next;
  logic done_reg;
  logic done_next;
  logic [15:0] select_reg;
  logic [15:0] select_next;
  logic [9:0] settle_cnt_reg;
  logic [9:0] settle_cnt_next;
  logic settled_reg;
  logic settled_next;
  logic settle_busy_reg;
  logic settle_busy_next;
  mux16_sar_adc_pkg::result_t ladder_trial_reg;
  mux16_sar_adc_pkg::result_t ladder_trial_next;
  logic trig_rise;
  logic trig_fall;

  // trigger edge detector; idles low so reset makes no false rise
  always_comb begin
    trig_next = conversion_trigger;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_reg <= 1'b0;
    end else begin
      trig_reg <= trig_next;
    end
  end

  // edges of the trigger against last clock's level
  always_comb begin
    trig_rise = conversion_trigger & ~trig_reg;
    trig_fall = ~conversion_trigger & trig_reg;
  end

  // conversion sequencer
  always_comb begin
    state_next = state_reg;
    approximation_register_next = approximation_register_reg;
    trial_bit_next = trial_bit_reg;
    clk_cnt_next = clk_cnt_reg;
    bit_idx_next = bit_idx_reg;
    result_next = result_reg;
    done_next = done_reg;
    if (trig_rise) begin
      // a rise always wins, even mid-conversion
      state_next = mux16_sar_adc_pkg::CONV_ARMED;
      approximation_register_next = `ADC_RESULT_RESET;
      trial_bit_next = `ADC_SAR_FIRST_TRIAL;
      clk_cnt_next = 3'h0;
      bit_idx_next = 3'h0;
      done_next = 1'b0; // one clock after the rise
    end else begin
      unique case (state_reg)
        mux16_sar_adc_pkg::CONV_IDLE: begin
        end
        mux16_sar_adc_pkg::CONV_ARMED: begin
          if (trig_fall) begin
            state_next = mux16_sar_adc_pkg::CONV_RUN;
          end
        end
        mux16_sar_adc_pkg::CONV_RUN: begin
          clk_cnt_next = clk_cnt_reg + 3'h1;
          // decide at the last clock of each bit slot
          if (clk_cnt_reg == 3'(`ADC_CLKS_PER_BIT - 1)) begin
            if (comparator_above) begin
              // input above trial level keeps the bit
              approximation_register_next =
                approximation_register_reg | trial_bit_reg;
            end
            trial_bit_next = trial_bit_reg >> 1;
            bit_idx_next = bit_idx_reg + 3'h1;
            if (bit_idx_reg == 3'(`ADC_BITS_PER_CONV - 1)) begin
              state_next = mux16_sar_adc_pkg::CONV_IDLE;
              result_next = comparator_above ?
                (approximation_register_reg | trial_bit_reg) :
                approximation_register_reg;
              done_next = 1'b1;
            end
          end
        end
        default: begin
          // illegal code falls back to idle
          state_next = mux16_sar_adc_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= mux16_sar_adc_pkg::CONV_IDLE;
      approximation_register_reg <= `ADC_RESULT_RESET;
      trial_bit_reg <= `ADC_RESULT_RESET;
      clk_cnt_reg <= 3'h0;
      bit_idx_reg <= 3'h0;
      result_reg <= `ADC_RESULT_RESET;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      approximation_register_reg <= approximation_register_next;
      trial_bit_reg <= trial_bit_next;
      clk_cnt_reg <= clk_cnt_next;
      bit_idx_reg <= bit_idx_next;
      result_reg <= result_next;
      done_reg <= done_next;
    end
  end

  // trial level from flops, not a gate, so the ladder sees no glitch
  always_comb begin
    ladder_trial_next = approximation_register_next | trial_bit_next;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ladder_trial_reg <= `ADC_RESULT_RESET;
    end else begin
      ladder_trial_reg <= ladder_trial_next;
    end
  end

  // channel switch drive; lags the latch by one clock
  always_comb begin
    select_next = sel_bus.select_onehot;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      select_reg <= `ADC_SELECT_RESET;
    end else begin
      select_reg <= select_next;
    end
  end

  // settle indicator; advisory only, the controller owns the wait
  always_comb begin
    settle_cnt_next = settle_cnt_reg;
    settled_next = settled_reg;
    settle_busy_next = settle_busy_reg;
    if (sel_bus.latch_event) begin
      settle_cnt_next = 10'h000;
      settled_next = 1'b0;
      settle_busy_next = 1'b1;
    end else if (settle_busy_reg) begin
      settle_cnt_next = settle_cnt_reg + 10'h001;
      if (settle_cnt_reg == 10'(SETTLE_CYCLES - 1)) begin
        // counter parks after one span; an off channel never settles
        settled_next = sel_bus.channel_enabled;
        settle_busy_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt_reg <= 10'h000;
      settled_reg <= 1'b0;
      settle_busy_reg <= 1'b0;
    end else begin
      settle_cnt_reg <= settle_cnt_next;
      settled_reg <= settled_next;
      settle_busy_reg <= settle_busy_next;
    end
  end

  assign analog_select = select_reg;
  assign ladder_trial = ladder_trial_reg;
  assign conversion_result = result_reg;
  assign conversion_done = done_reg;
  assign channel_settled = settled_reg;
endmodule : mux16_sar_adc_control

// [mux16_sar_adc_properties.sv]
// assertions for the converter control, bound to its top module
module mux16_sar_adc_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic address_latch_strobe,
  input wire logic channel_expansion,
  input wire logic [3:0] channel_address,
  input wire logic conversion_trigger,
  input wire logic comparator_above,
  input wire logic [15:0] analog_select,
  input wire logic [7:0] ladder_trial,
  input wire logic [7:0] conversion_result,
  input wire logic conversion_done,
  input wire logic channel_settled
);
  timeunit 1ns;
  timeprecision 1ps;
  logic strobe_q, rise1, rise2;
  // select may only move two samples after a strobe rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {strobe_q, rise1, rise2} <= 3'h0;
    end else begin
      strobe_q <= address_latch_strobe;
      rise1 <= address_latch_strobe & ~strobe_q;
      rise2 <= rise1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  onehot_select_a:
    assert property ($onehot0(analog_select)) else $error("select not onehot");
  select_decode_a:
    assert property ($rose(address_latch_strobe) && channel_expansion |->
      ##3 analog_select == 16'h0001 << $past(channel_address, 3))
      else $error("wrong channel");
  select_off_a:
    assert property ($rose(address_latch_strobe) && !channel_expansion |->
      ##3 analog_select == 16'h0000) else $error("channel not off");
  select_hold_a:
    assert property ($changed(analog_select) |-> rise2)
      else $error("select moved without strobe");
  done_fall_a:
    assert property ($rose(conversion_trigger) |-> ##[1:8] !conversion_done)
      else $error("done did not fall");
  first_trial_a:
    assert property ($rose(conversion_trigger) ##2 conversion_trigger |->
      ladder_trial == 8'h80) else $error("trial not cleared");
  run_length_a:
    assert property ($rose(conversion_done) |->
      !$past(conversion_trigger, 65) && $past(conversion_trigger, 66))
      else $error("conversion length wrong");
  no_early_done_a:
    assert property ($fell(conversion_trigger) |->
      ##1 (!conversion_done)[*8])
      else $error("done too early");
  result_hold_a:
    assert property ($changed(conversion_result) |-> $rose(conversion_done))
      else $error("result moved");
  cover property ($rose(conversion_done));
  cover property ($rose(conversion_trigger) && !conversion_done);
  cover property ($rose(address_latch_strobe) && !channel_expansion);
endmodule : mux16_sar_adc_properties
bind mux16_sar_adc_control mux16_sar_adc_properties i_props (.clk(clk),
  .rst_n(rst_n), .address_latch_strobe(address_latch_strobe),
  .channel_expansion(channel_expansion), .channel_address(channel_address),
  .conversion_trigger(conversion_trigger),
  .comparator_above(comparator_above), .analog_select(analog_select),
  .ladder_trial(ladder_trial), .conversion_result(conversion_result),
  .conversion_done(conversion_done), .channel_settled(channel_settled));

// [comparator_model.sv]
// analog side: channel i holds level 11h times i, all off reads zero
module comparator_model (
  input wire logic [15:0] analog_select,
  input wire logic [7:0] ladder_trial,
  output logic comparator_above
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] level;
  always_comb begin
    level = 8'h00;
    for (int i = 0; i < 16; i++)
      if (analog_select[i]) level = 8'h11 * i[7:0];
    comparator_above = level >= ladder_trial;
  end
endmodule : comparator_model

// [mux16_sar_adc_control_tb_top.sv]
// testbench for the converter control
module mux16_sar_adc_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic e; logic [3:0] a; logic [15:0] s; logic [7:0] r;} row_t;
  row_t rows [4] = '{'{1'b1, 4'h0, 16'h0001, 8'h00},
    '{1'b1, 4'hf, 16'h8000, 8'hff}, '{1'b1, 4'h6, 16'h0040, 8'h66},
    '{1'b0, 4'h9, 16'h0000, 8'h00}};
  logic clk = 1'b0, rst_n = 1'b0, als = 1'b0, ce = 1'b0, trg = 1'b0;
  logic [3:0] ca = 4'h0;
  logic above, done, settled;
  logic [15:0] sel;
  logic [7:0] trial, res;
  int failures = 0, n_checks = 0;
  always #2 clk = ~clk;
  mux16_sar_adc_control i_mux16_sar_adc_control (.clk(clk), .rst_n(rst_n),
    .address_latch_strobe(als), .channel_expansion(ce),
    .channel_address(ca), .conversion_trigger(trg),
    .comparator_above(above), .analog_select(sel), .ladder_trial(trial),
    .conversion_result(res), .conversion_done(done),
    .channel_settled(settled));
  comparator_model i_comparator_model (.analog_select(sel),
    .ladder_trial(trial), .comparator_above(above));
  task automatic chk(input string nm, input logic [15:0] seen, ex);
    n_checks++;
    if (seen !== ex) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  // strobe held one cycle, address steady around its rise
  task automatic latch(input logic e, input logic [3:0] a);
    @(posedge clk);
    ce <= e;
    ca <= a;
    als <= 1'b1;
    @(posedge clk);
    als <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : latch
  task automatic conv();
    int n;
    n = 0;
    @(posedge clk);
    trg <= 1'b1;
    repeat (3) @(posedge clk);
    chk("done_low", {15'h0, done}, 16'h0);
    chk("trial_first", {8'h0, trial}, 16'h0080);
    trg <= 1'b0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("done_seen", {15'h0, done}, 16'h1);
    // 66 clocks after the fall, counted from three clocks after the rise
    chk("run_cycles", 16'(n), 16'h0042);
  endtask : conv
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    // tests take about 4200 clocks; the limit leaves ample room
    #30000;
    failures++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clk);
    chk("select_rst", sel, 16'h0);
    chk("done_rst", {15'h0, done}, 16'h0);
    chk("trial_rst", {8'h0, trial}, 16'h0);
    chk("result_rst", {8'h0, res}, 16'h0);
    chk("settled_rst", {15'h0, settled}, 16'h0);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      latch(rows[i].e, rows[i].a);
      chk("select", sel, rows[i].s);
      repeat (625) @(posedge clk);
      chk("settled", {15'h0, settled}, {15'h0, rows[i].e});
      conv();
      chk("result", {8'h0, res}, {8'h0, rows[i].r});
    end
    // abandoned run must not leave a stale code behind
    latch(1'b1, 4'hc);
    repeat (625) @(posedge clk);
    trg <= 1'b1;
    repeat (3) @(posedge clk);
    trg <= 1'b0;
    repeat (20) @(posedge clk);
    conv();
    chk("restart", {8'h0, res}, 16'h00cc);
    // reset in mid-conversion must clear select, trial and result at once
    trg <= 1'b1;
    repeat (2) @(posedge clk);
    trg <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    chk("select_mid", sel, 16'h0);
    chk("trial_mid", {8'h0, trial}, 16'h0);
    chk("result_mid", {8'h0, res}, 16'h0);
    rst_n <= 1'b1;
    latch(1'b1, 4'h3);
    chk("settle_early", {15'h0, settled}, 16'h0);
    repeat (630) @(posedge clk);
    chk("settle_late", {15'h0, settled}, 16'h1);
    summarize();
  end
endmodule : mux16_sar_adc_control_tb_top
